// ---- src/frag_engine.sv ----
// Purpose: splits a pending upstream frame across partial grants
// Assumes: grant, frame and next-packet inputs come from same-clock logic
// Notes: one frame in flight; fragment descriptors drive the burst builder
// Operation
// - No grant queued at fragmentation start: piggyback remainder request.
// - Partial grant yields one fragment holding exactly what fits.
// - Modem keeps its own record of untransmitted bytes.
// - Piggyback byte covers remainder plus fragment and PHY overhead.
// - Re-request on each ack expiry; drop frame when retries run out.
// - Payload room is grant capacity minus PHY overhead minus 16.
// - Layout header, check, payload, CRC; first one marked first.
// - Further grants queued: zero piggyback, wait for next grant.
// - None queued: piggyback remainder slots, start ack timer.
// - Ack expiry while fragmenting: request remainder plus overheads.
// - Later grant holding remainder plus overhead carries last fragment.
// - Otherwise middle fragment, piggyback chosen by queued-grant check.
// - Last fragment request: next packet slots, else zero.
// - After last fragment resume normal; small grant restarts fragmenting.
// - Concatenated frame fragmented as one unit, ignoring inner bounds.
// - First: F set L clear; middle: both clear; last: L only.
// - Sequence number steps by one per fragment sent.
// - Immediate-region frames are never fragmented.
// - Pending indication with fragment grant: no piggyback in it.
//
// Design decisions made here: register access over APB and the address map.
module frag_engine
	import frag_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Frame to send and next queued packet
	input wire frame_s frame_in,
	output logic frame_ready,
	input wire logic next_valid,
	input wire logic [15:0] next_len,
	// Grants decoded from allocation messages
	input wire grant_s grant,
	// Fragment descriptor toward the burst builder
	output frag_s frag_out,
	input wire logic tx_ready,
	// Standalone requests and frame outcome
	output req_s req_out,
	output logic frame_done,
	output logic frame_drop
);

	typedef struct packed {
		fsm_e st;
		logic [15:0] remain;
		logic [15:0] offset;
		logic [3:0] seq;
		logic fragging;
		logic imm;
		logic [7:0] retries;
		logic [19:0] timer;
		frag_s frag;
		req_s req;
		logic done;
		logic drop;
		logic en;
		logic [7:0] retry_max;
		logic [7:0] physical_layer_overhead;
		logic [3:0] shift;
		logic [19:0] ack_cyc;
		logic [31:0] rdata;
		logic err;
		logic [15:0] frag_cnt;
		logic [15:0] drop_cnt;
	} state_s;

	state_s q, d;

	// Mini-slots covering a byte count plus PHY overhead
	function automatic logic [15:0] slots_for(
		input logic [15:0] b,
		input logic [7:0] physical_layer_overhead,
		input logic [3:0] sh
	);
		logic [16:0] t;
		logic [16:0] m;
		m = (17'h00001 << sh) - 17'h00001;
		t = {1'b0, b} + {9'h000, physical_layer_overhead} + m;
		slots_for = 16'(t >> sh);
	endfunction : slots_for

	// Piggyback field is one byte; larger needs saturate
	function automatic logic [7:0] sat8(input logic [15:0] v);
		sat8 = (v > {8'h00, PIGGY_MAX}) ? PIGGY_MAX : v[7:0];
	endfunction : sat8

	logic [15:0] cap;
	logic [15:0] room;
	logic [15:0] raw;
	logic fits;
	logic hold_req;
	logic [7:0] idx;

	always_comb
	begin
		raw = 16'({8'h00, grant.slots} << q.shift);
		cap = (raw > {8'h00, q.physical_layer_overhead}) ? raw - {8'h00, q.physical_layer_overhead} : 16'h0000;
		room = (cap > FRAG_OVH) ? cap - FRAG_OVH : 16'h0000;
		// Mid-frame the header, check and CRC must fit as well
		fits = q.fragging ? (room >= q.remain) : (cap >= q.remain);
		hold_req = grant.queued | grant.pending;
		idx = paddr;
	end

	always_comb
	begin
		d = q;
		d.req.valid = 1'b0;
		d.done = 1'b0;
		d.drop = 1'b0;
		d.err = 1'b0;

		// Register bus: data prepared in setup, answered in access
		if (psel && !penable)
		begin
			d.rdata = 32'h00000000;
			if (idx == OFS_CTRL)
			begin
				d.rdata[CTRL_EN] = q.en;
				d.rdata[CTRL_RETRY +: 8] = q.retry_max;
			end
			else if (idx == OFS_PHY)
			begin
				d.rdata[7:0] = q.physical_layer_overhead;
				d.rdata[PHY_SHIFT +: 4] = q.shift;
			end
			else if (idx == OFS_ACK)
				d.rdata[19:0] = q.ack_cyc;
			else if (idx == OFS_STAT)
				d.rdata = {q.remain, q.seq, 6'h00, q.fragging,
					q.imm, q.st != ST_IDLE, 3'h0};
			else if (idx == OFS_CNT)
				d.rdata = {q.drop_cnt, q.frag_cnt};
			else
				d.err = 1'b1;
		end
		// Writes land at the access edge, where the master sees ready
		if (psel && penable && pwrite)
		begin
			if (idx == OFS_CTRL)
			begin
				d.en = pwdata[CTRL_EN];
				d.retry_max = pwdata[CTRL_RETRY +: 8];
			end
			else if (idx == OFS_PHY)
			begin
				d.physical_layer_overhead = pwdata[7:0];
				d.shift = pwdata[PHY_SHIFT +: 4];
			end
			else if (idx == OFS_ACK)
				d.ack_cyc = pwdata[19:0];
		end

		case (q.st)
			ST_IDLE:
			begin
				if (frame_in.valid)
				begin
					// Concatenated frames arrive as one length
					d.remain = frame_in.len;
					d.offset = 16'h0000;
					d.seq = 4'h0;
					d.fragging = 1'b0;
					d.imm = frame_in.immediate;
					d.retries = 8'h00;
					d.req.valid = 1'b1;
					d.req.slots = slots_for(frame_in.len, q.physical_layer_overhead, q.shift);
					d.timer = q.ack_cyc;
					d.st = ST_WAIT;
				end
			end
			ST_WAIT:
			begin
				if (grant.valid && grant.slots == 8'h00)
					d.timer = q.ack_cyc;
				else if (grant.valid && fits)
				begin
					d.frag.whole = !q.fragging;
					d.frag.first = 1'b0;
					d.frag.last = q.fragging;
					d.frag.seq = q.seq;
					d.frag.offset = q.offset;
					d.frag.len = q.remain;
					d.frag.piggy = 8'h00;
					if (next_valid && !hold_req)
						d.frag.piggy = sat8(slots_for(next_len,
							q.physical_layer_overhead, q.shift));
					d.frag.valid = 1'b1;
					d.st = ST_SEND;
				end
				else if (grant.valid && q.en && !q.imm &&
					room != 16'h0000)
				begin
					// Partial grant: fill it with as much as fits
					d.frag.whole = 1'b0;
					d.frag.first = !q.fragging;
					d.frag.last = 1'b0;
					d.frag.seq = q.seq;
					d.frag.offset = q.offset;
					d.frag.len = room;
					d.frag.piggy = 8'h00;
					if (!hold_req)
						d.frag.piggy = sat8(slots_for(
							q.remain - room + FRAG_OVH,
							q.physical_layer_overhead, q.shift));
					d.fragging = 1'b1;
					d.frag.valid = 1'b1;
					d.st = ST_SEND;
				end
				else if (q.timer == 20'h00000)
				begin
					d.retries = q.retries + 8'h01;
					if (q.retries >= q.retry_max)
					begin
						d.drop = 1'b1;
						d.drop_cnt = q.drop_cnt + 16'h0001;
						d.remain = 16'h0000;
						d.offset = 16'h0000;
						d.seq = 4'h0;
						d.fragging = 1'b0;
						d.st = ST_IDLE;
					end
					else
					begin
						d.req.valid = 1'b1;
						d.req.slots = slots_for(q.fragging ?
							q.remain + FRAG_OVH : q.remain,
							q.physical_layer_overhead, q.shift);
						d.timer = q.ack_cyc;
					end
				end
				else
					d.timer = q.timer - 20'h00001;
			end
			ST_SEND:
			begin
				if (tx_ready)
				begin
					d.frag.valid = 1'b0;
					d.remain = q.remain - q.frag.len;
					d.offset = q.offset + q.frag.len;
					d.retries = 8'h00;
					d.timer = q.ack_cyc;
					if (!q.frag.whole)
					begin
						d.seq = q.seq + 4'h1;
						d.frag_cnt = q.frag_cnt + 16'h0001;
					end
					if (q.frag.whole || q.frag.last)
					begin
						d.done = 1'b1;
						d.remain = 16'h0000;
						d.offset = 16'h0000;
						d.seq = 4'h0;
						d.fragging = 1'b0;
						d.st = ST_IDLE;
					end
					else
						d.st = ST_WAIT;
				end
			end
			default:
				d.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			q <= '0;
			q.st <= ST_IDLE;
			q.retry_max <= RETRY_RST;
			q.physical_layer_overhead <= POH_RST;
			q.shift <= SHIFT_RST;
			q.ack_cyc <= ACK_CYC_RST;
		end
		else
			q <= d;
	end

	// Zero-wait slave: access phase always completes
	assign pready = psel & penable;
	assign pslverr = psel & penable & q.err;
	assign prdata = q.rdata;
	assign frame_ready = (q.st == ST_IDLE);
	assign frag_out = q.frag;
	assign req_out = q.req;
	assign frame_done = q.done;
	assign frame_drop = q.drop;

endmodule : frag_engine

// ---- src/frag_pkg.sv ----
// Purpose: shared types and constants of the upstream fragmentation engine
// Assumes: one 250 MHz clock, byte-sized frame lengths
// Notes: register offsets are byte addresses on APB
package frag_pkg;
	localparam int CLK_NS = 4;
	localparam int ACK_TIME_NS = 10000;
	localparam logic [19:0] ACK_CYC_RST = 20'(ACK_TIME_NS / CLK_NS);
	localparam logic [15:0] FRAG_OVH = 16'h0010;
	localparam logic [7:0] PIGGY_MAX = 8'hFF;
	localparam logic [7:0] RETRY_RST = 8'h10;
	localparam logic [7:0] POH_RST = 8'h1C;
	localparam logic [3:0] SHIFT_RST = 4'h4;
	// Register map
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PHY = 8'h04;
	localparam logic [7:0] OFS_ACK = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	localparam logic [7:0] OFS_CNT = 8'h10;
	// Field positions
	localparam int CTRL_EN = 0;
	localparam int CTRL_RETRY = 8;
	localparam int PHY_SHIFT = 8;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SEND} fsm_e;
	typedef struct packed {
		logic valid;
		logic [15:0] len;
		logic immediate;
	} frame_s;
	typedef struct packed {
		logic valid;
		logic [7:0] slots;
		logic pending;
		logic queued;
	} grant_s;
	typedef struct packed {
		logic valid;
		logic whole;
		logic first;
		logic last;
		logic [3:0] seq;
		logic [15:0] offset;
		logic [15:0] len;
		logic [7:0] piggy;
	} frag_s;
	typedef struct packed {
		logic valid;
		logic [15:0] slots;
	} req_s;
endpackage : frag_pkg

// ---- testbench/frag_engine_asserts.sv ----
// Purpose: port assertions for frag_engine
// Assumes: one clock, async high reset
// Notes: bound after the module
module frag_engine_asserts
	import frag_pkg::*;
(
	// Clock
	input wire logic clk,
	input wire logic rst,
	// Watched
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire frame_s frame_in,
	input wire logic frame_ready,
	input wire grant_s grant,
	input wire frag_s frag_out,
	input wire logic tx_ready,
	input wire req_s req_out,
	input wire logic frame_done,
	input wire logic frame_drop
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_rdy; psel && penable |-> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	property p_req;
		frame_ready && frame_in.valid |=> req_out.valid;
	endproperty
	a_req: assert property (p_req) else $error("no request");
	property p_hold;
		frag_out.valid && !tx_ready |=> $stable(frag_out);
	endproperty
	a_hold: assert property (p_hold) else $error("fragment moved");
	property p_clr; frag_out.valid && tx_ready |=> !frag_out.valid; endproperty
	a_clr: assert property (p_clr) else $error("fragment stuck");
	property p_flag;
		frag_out.valid && !frag_out.whole |-> !(frag_out.first && frag_out.last);
	endproperty
	a_flag: assert property (p_flag) else $error("bad flags");
	property p_seq;
		frag_out.valid && frag_out.first |-> frag_out.seq == 4'h0;
	endproperty
	a_seq: assert property (p_seq) else $error("bad sequence");
	// Held grant means the answering fragment asks for nothing
	property p_zero;
		grant.valid && (grant.pending || grant.queued) ##1 $rose(frag_out.valid)
			|-> frag_out.piggy == 8'h00;
	endproperty
	a_zero: assert property (p_zero) else $error("piggyback set");
	property p_done;
		frag_out.valid && tx_ready && frag_out.last |=> frame_done;
	endproperty
	a_done: assert property (p_done) else $error("no done");
	c_mid: cover property (frag_out.valid && !frag_out.first && !frag_out.last);
	c_drop: cover property (frame_drop);
	c_done: cover property (frame_done);
endmodule : frag_engine_asserts
bind frag_engine frag_engine_asserts chk_u (.clk, .rst, .psel, .penable,
	.pready, .frame_in, .frame_ready, .grant, .frag_out, .tx_ready, .req_out,
	.frame_done, .frame_drop);

// ---- testbench/headend_model.sv ----
// Purpose: headend scheduler stand-in
// Assumes: grants come four cycles after a request
// Notes: grants capped at max_slots; zero cap means silence
module headend_model
	import frag_pkg::*;
(
	// Clock
	input wire logic clk,
	input wire logic rst,
	// Modem side
	input wire req_s req_out,
	input wire frag_s frag_out,
	output grant_s grant,
	output logic tx_ready,
	// Reassembled frame
	output logic rx_done,
	output logic [15:0] rx_len,
	// Bench controls
	input wire logic [7:0] max_slots,
	input wire logic mg,
	input wire logic stall
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] v;
	logic [15:0] asm_q;
	logic [7:0] due_q;
	logic [1:0] dly_q;
	assign tx_ready = !stall;
	assign v = req_out.valid ? req_out.slots : 16'(frag_out.piggy);
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			grant <= '0;
			due_q <= 8'h00;
			dly_q <= 2'h0;
			asm_q <= 16'h0000;
			rx_done <= 1'h0;
			rx_len <= 16'h0000;
		end
		else
		begin
			grant <= '0;
			rx_done <= 1'h0;
			if (frag_out.valid && tx_ready && !frag_out.whole)
			begin
				// Reassembly: summed pieces must give the frame length
				asm_q <= frag_out.last ? 16'h0000 : asm_q + frag_out.len;
				if (frag_out.last)
				begin
					rx_done <= 1'h1;
					rx_len <= asm_q + frag_out.len;
				end
			end
			// Requests inside the finished frame are left unused: allowed
			if (req_out.valid || (frag_out.valid && tx_ready &&
				!frag_out.last && !frag_out.whole))
			begin
				// Zero piggyback: grant the cap, as multiple grant mode does
				due_q <= (v == 16'h0 || v > 16'(max_slots)) ?
					max_slots : v[7:0];
				dly_q <= 2'h3;
			end
			else if (dly_q != 2'h0)
			begin
				dly_q <= dly_q - 2'h1;
				if (dly_q == 2'h1 && due_q != 8'h00)
					grant <= '{1'h1, due_q, mg, 1'h0};
			end
		end
endmodule : headend_model

// ---- testbench/tb_upstream_fragmentation_engine.sv ----
// Purpose: self-checking bench for frag_engine
// Assumes: headend_model answers every request
// Notes: ack time cut to 128 cycles
module tb_upstream_fragmentation_engine
	import frag_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic mg = 1'h0, next_valid = 1'h1, stall = 1'h0, pready, pslverr;
	logic frame_ready, tx_ready, frame_done, frame_drop;
	logic [7:0] paddr = 8'h00, mx = 8'h00;
	logic fen = 1'h1, rx_done;
	logic [15:0] next_len = 16'h0000, rx_len;
	logic [31:0] pwdata = 32'h0, prdata, rs = 32'h01F35231;
	frame_s frame_in = '0;
	grant_s grant;
	frag_s frag_out;
	req_s req_out;
	int mismatches = 0, tests_run = 0, nfr = 0;
	logic [63:0] q[5][$];
	string nm[5] = '{"apb", "req", "frag", "end", "asm"};
	frag_engine dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .frame_in, .frame_ready, .next_valid,
		.next_len, .grant, .frag_out, .tx_ready, .req_out, .frame_done,
		.frame_drop);
	headend_model hm_u (.clk, .rst, .req_out, .frag_out, .max_slots(mx), .mg,
		.stall, .grant, .tx_ready, .rx_done, .rx_len);
	initial
		forever #2 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction : xs
	// Mini-slots for b bytes plus PHY overhead, saturated
	function automatic int sl(input int b);
		b = (b + POH_RST + (1 << SHIFT_RST) - 1) >> SHIFT_RST;
		return b > 255 ? 255 : b;
	endfunction : sl
	always @(posedge clk)
	begin
		rs <= xs(rs);
		stall <= rs[0];
	end
	task chk(input int k, input logic [63:0] s);
		logic [63:0] e;
		e = q[k].size() ? q[k].pop_front() : '1;
		tests_run++;
		if (e !== s)
		begin
			mismatches++;
			$display("wrong value %s exp %h seen %h", nm[k], e, s);
		end
	endtask : chk
	task chk_apb(input logic [63:0] s);
		chk(0, s);
	endtask : chk_apb
	task chk_req(input logic [63:0] s);
		chk(1, s);
	endtask : chk_req
	task chk_frag(input logic [63:0] s);
		chk(2, s);
	endtask : chk_frag
	task chk_end(input logic [63:0] s);
		chk(3, s);
	endtask : chk_end
	task chk_asm(input logic [63:0] s);
		chk(4, s);
	endtask : chk_asm
	always @(posedge clk)
		if (!rst)
		begin
			if (psel && penable && pready === 1'h1 && !pwrite)
				chk_apb(64'({pslverr, prdata}));
			if (req_out.valid === 1'h1)
				chk_req(64'(req_out.slots));
			if (frag_out.valid === 1'h1 && tx_ready)
				chk_frag(64'(frag_out));
			if (frame_done === 1'h1 || frame_drop === 1'h1)
				chk_end(64'({frame_drop, frame_done}));
			if (rx_done === 1'h1)
				chk_asm(64'(rx_len));
		end
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do
			@(posedge clk);
		while (pready !== 1'h1);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task frame(input int len, input logic [7:0] m, input logic g, input logic im);
		int rem, off, sq, p, room;
		logic lst, nofrag;
		@(posedge clk);
		mg <= g;
		mx <= m;
		next_valid <= rs[10];
		next_len <= {6'h00, rs[9:0]};
		frame_in <= '{1'h1, 16'(len), im};
		@(posedge clk);
		frame_in.valid <= 1'h0;
		p = sl(len);
		q[1].push_back(64'(p));
		// Immediate frames and a disabled engine never split
		nofrag = im || !fen;
		rem = nofrag ? 0 : len;
		off = 0;
		sq = 0;
		while (rem > 0)
		begin
			room = (((p == 0 || p > m) ? m : p) << SHIFT_RST) - POH_RST - 16;
			lst = room >= rem;
			p = lst ? (next_valid && !g ? sl(next_len) : 0)
				: (g ? 0 : sl(rem - room + 16));
			q[2].push_back(64'({2'h2, sq == 0, lst, 4'(sq), 16'(off),
				16'(lst ? rem : room), 8'(p)}));
			rem -= room;
			off += room;
			sq++;
		end
		nfr += sq;
		if (sq > 0)
			q[4].push_back(64'(len));
		if (nofrag)
		begin
			q[1].push_back(64'(p));
			q[1].push_back(64'(p));
		end
		q[3].push_back(nofrag ? 64'h2 : 64'h1);
		for (int i = 0; i < 3000 && q[3].size() > 0; i++) @(posedge clk);
		$display("frame of %0d bytes, %0d fragments, done", len, sq);
	endtask : frame
	task end_sim;
		// Notes never consumed are results that did not appear
		foreach (q[k])
			mismatches += q[k].size();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_sim;
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		q[0].push_back(64'h1000);
		apb(1'h0, OFS_CTRL, 32'h0);
		q[0].push_back(64'h100000000);
		apb(1'h0, 8'h20, 32'h0);
		apb(1'h1, OFS_CTRL, 32'h0201);
		apb(1'h1, OFS_ACK, 32'h0080);
		q[0].push_back(64'({20'h00000, SHIFT_RST, POH_RST}));
		apb(1'h0, OFS_PHY, 32'h0);
		q[0].push_back(64'h80);
		apb(1'h0, OFS_ACK, 32'h0);
		frame(1018, 8'h3A, 1'h0, 1'h0);
		frame(1018, 8'h14, 1'h0, 1'h0);
		frame(1018, 8'h3A, 1'h1, 1'h0);
		frame(1018, 8'h14, 1'h1, 1'h0);
		frame(1018, 8'h3A, 1'h0, 1'h1);
		apb(1'h1, OFS_CTRL, 32'h0200);
		fen = 1'h0;
		frame(1018, 8'h3A, 1'h0, 1'h0);
		q[0].push_back(64'({16'h2, 16'(nfr)}));
		apb(1'h0, OFS_CNT, 32'h0);
		@(posedge clk);
		end_sim;
	end
endmodule : tb_upstream_fragmentation_engine
